// [core/i2c_flags_pkg.sv]
// Purpose: Shared constants and types for the two-wire address flag and acknowledge block
// Assumes: Byte-wide register port, one 200 MHz clock
// Notes:   Every offset, field position, reset value and timing count lives here
package i2c_flags_pkg;

    // Clock and link timing
    localparam int        CLK_PERIOD_PS   = 5000;
    localparam int        FRAME_BITS      = 8;
    localparam logic [3:0] LAST_BIT_IDX   = 4'(FRAME_BITS - 1);

    // Register offsets
    localparam logic [7:0] OFF_STATUS     = 8'h00;
    localparam logic [7:0] OFF_CONTROL    = 8'h01;
    localparam logic [7:0] OFF_STC        = 8'h02;
    localparam logic [7:0] OFF_OWN_ADDR   = 8'h03;
    localparam logic [7:0] OFF_DATA       = 8'h04;
    localparam logic [7:0] OFF_BUS_MODE   = 8'h05;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h06;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h07;

    // Status register fields
    localparam int        BIT_OWN_MATCH   = 2;
    localparam int        BIT_BCAST       = 1;
    localparam int        BIT_ACK         = 0;

    // Control register fields
    localparam int        BIT_TX_SEL      = 0;
    localparam int        BIT_MASTER      = 1;
    localparam int        BIT_FMT_SEL     = 2;
    localparam int        BIT_FMT_SEL2    = 3;

    // Serial/timer control fields
    localparam int        BIT_RATE_HI     = 6;
    localparam int        BIT_RATE_LO     = 5;
    localparam int        BIT_REG_GATE    = 4;

    // Interrupt status fields
    localparam int        IRQ_OWN_MATCH   = 0;
    localparam int        IRQ_BCAST       = 1;
    localparam int        IRQ_BYTE_DONE   = 2;

    // Reset values and fixed codes
    localparam logic [7:0] STC_RESET      = 8'h00;
    localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
    localparam logic [7:0] GEN_CALL_ADDR  = 8'h00;
    localparam logic       ACK_RESET      = 1'b0;

    // Master rate divider: base count shifted by clock select, plus extension step
    localparam logic [11:0] RATE_BASE     = 12'h014;
    localparam int          RATE_EXT_SH   = 3;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_FRAME,
        LINK_ACK
    } link_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        link_state_t state;
        logic [3:0]  bit_cnt;
        logic        first_frame;
        logic        addressed;
        logic [7:0]  rx_shift;
        logic [7:0]  tx_shift;
        logic        scl_prev;
        logic        sda_prev;
        logic        own_flag;
        logic        bcast_flag;
        logic        own_armed;
        logic        bcast_armed;
        logic        ack_tx;
        logic        ack_rx;
        logic [3:0]  ctrl;
        logic [7:0]  stc;
        logic [7:0]  own_addr;
        logic [7:0]  data;
        logic [2:0]  clk_sel;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [7:0]  rd_data;
        logic        sda_oe;
    } state_t;

endpackage

// [core/pin_sync.sv]
// Purpose: Two-stage synchroniser for pins from outside the clock domain
// Assumes: Inputs are slow levels compared with ref_clk
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] meta_q;

    // Idle bus level is high, so both stages reset high
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q       <= '1;
            pin_sync_out <= '1;
        end else begin
            meta_q       <= pin_in;
            pin_sync_out <= meta_q;
        end
    end

endmodule // pin_sync

// [core/rate_divider.sv]
// Purpose: Master bit-rate enable generator
// Assumes: Divisor is at least 2
// Notes:   Restarts whenever disabled, so a new rate takes effect cleanly
`timescale 1ns/1ps
module rate_divider (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        enable,
    input  wire logic [11:0] divisor,
    output logic             tick
);

    logic [11:0] cnt_q;

    // One-cycle pulse every divisor cycles while enabled
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 12'h000;
            tick  <= 1'b0;
        end else if (!enable) begin
            cnt_q <= 12'h000;
            tick  <= 1'b0;
        end else if (cnt_q >= divisor - 12'h001) begin
            cnt_q <= 12'h000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 12'h001;
            tick  <= 1'b0;
        end
    end

endmodule // rate_divider

// [core/i2c_addr_flags_ack_ctrl.sv]
// Purpose: Address recognition flags, acknowledge bit and serial/timer control of a two-wire bus unit
// Assumes: Byte register port, scl/sda pins asynchronous to ref_clk, hw_standby from same-clock logic
// Notes:   Flags are held clear while master mode is selected
// What this block does
// - In slave receive with format select 0, an own or general call address sets the own-address match flag.
// - The own-address match flag clears on read-1-then-write-0, on a data access in its direction, and in master mode.
// - In slave receive with either format select at 0, a general call first frame sets the broadcast flag.
// - The broadcast flag clears on read-1-then-write-0, on a data access in its direction, and in master mode.
// - While transmitting, the acknowledge from the receiver is captured and read back.
// - While receiving as an addressed slave, the programmed acknowledge is driven after each byte and read back.
// - A write to the acknowledge bit changes only the value to send, never the captured one.
// - Acknowledge 0 means drive low or acknowledged, 1 means release the line or not acknowledged, reset 0.
// - The serial/timer control register is 8 bits read/write and clears on reset and hardware standby.
// - Rate extension bits 6 and 5 with the three clock select bits set the master bit rate.
// - Register gate 0 blocks the bus unit registers and opens the async serial ones; 1 opens bus and PWM ones.
// - The first frame after a start is eight bits and carries the compared address.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module i2c_addr_flags_ack_ctrl
    import i2c_flags_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    input  wire logic                    hw_standby,
    input  wire i2c_flags_pkg::reg_req_t reg_req,
    output logic [7:0]                   rd_data,
    output logic                         irq,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe,
    output logic                         master_rate_tick,
    output logic                         async_serial_access_en,
    output logic                         pwm_access_en
);
    import i2c_flags_pkg::*;

    state_t      q;
    state_t      d;
    logic [1:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        start_det;
    logic        stop_det;
    logic        scl_rise;
    logic        scl_fall;
    logic        tx_mode;
    logic        master;
    logic        slave_rx;
    logic        byte_end;
    logic        own_hit;
    logic        gc_hit;
    logic        addr_done;
    logic        data_clr;
    logic        status_wr;
    logic [7:0]  rd_val;
    logic [11:0] rate_div;

    // Bus unit registers that the gate bit can hide from software
    function automatic logic gated_reg(input logic [7:0] a);
        gated_reg = (a == OFF_STATUS) || (a == OFF_CONTROL) || (a == OFF_OWN_ADDR) ||
                    (a == OFF_DATA) || (a == OFF_BUS_MODE);
    endfunction

    // Rate extension bits and clock select give the bit period in system clocks
    function automatic logic [11:0] rate_divisor(input logic [1:0] ext, input logic [2:0] cks);
        rate_divisor = (RATE_BASE << cks) + 12'({ext, 3'b000});
    endfunction

    // Both pins pass two flops before anything looks at them
    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .pin_in       ({scl_i, sda_i}),
        .pin_sync_out (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Master rate from extension bits 6..5 and bus mode clock select
    assign rate_div = rate_divisor({q.stc[BIT_RATE_HI], q.stc[BIT_RATE_LO]}, q.clk_sel);

    rate_divider u_rate_divider (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .enable  (master),
        .divisor (rate_div),
        .tick    (master_rate_tick)
    );

    // Bus events from the synchronised levels
    assign scl_rise  = scl_s && !q.scl_prev;
    assign scl_fall  = !scl_s && q.scl_prev;
    assign start_det = scl_s && q.scl_prev && q.sda_prev && !sda_s;
    assign stop_det  = scl_s && q.scl_prev && !q.sda_prev && sda_s;
    assign tx_mode   = q.ctrl[BIT_TX_SEL];
    assign master    = q.ctrl[BIT_MASTER];
    assign slave_rx  = !master && !tx_mode;

    // Eighth rising edge of a frame completes the byte
    assign byte_end  = (q.state == LINK_FRAME) && scl_rise && (q.bit_cnt == LAST_BIT_IDX);
    assign addr_done = byte_end && q.first_frame;
    assign own_hit   = ({q.rx_shift[6:0], sda_s} >> 1) == (q.own_addr >> 1);
    assign gc_hit    = {q.rx_shift[6:0], sda_s} == GEN_CALL_ADDR;

    // Data register access in the current direction clears the address flags
    assign data_clr  = q.stc[BIT_REG_GATE] && (reg_req.addr == OFF_DATA) &&
                       ((reg_req.wr && tx_mode) || (reg_req.rd && !tx_mode));
    assign status_wr = reg_req.wr && q.stc[BIT_REG_GATE] && (reg_req.addr == OFF_STATUS);

    // Read mux; gated registers read as zero when hidden
    always_comb begin
        rd_val = 8'h00;
        if (!gated_reg(reg_req.addr) || q.stc[BIT_REG_GATE]) begin
            case (reg_req.addr)
                OFF_STATUS:   rd_val = {5'h00, q.own_flag, q.bcast_flag,
                                        tx_mode ? q.ack_rx : q.ack_tx};
                OFF_CONTROL:  rd_val = {4'h0, q.ctrl};
                OFF_STC:      rd_val = q.stc;
                OFF_OWN_ADDR: rd_val = q.own_addr;
                OFF_DATA:     rd_val = q.data;
                OFF_BUS_MODE: rd_val = {5'h00, q.clk_sel};
                OFF_IRQ_STAT: rd_val = {5'h00, q.irq_stat};
                OFF_IRQ_MASK: rd_val = {5'h00, q.irq_mask};
                default:      rd_val = 8'h00;
            endcase
        end
    end

    // Next-state logic for registers, link tracking and flags
    always_comb begin
        d          = q;
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;
        d.rd_data  = reg_req.rd ? rd_val : 8'h00;

        // Register writes; hidden registers ignore writes
        if (reg_req.wr && (!gated_reg(reg_req.addr) || q.stc[BIT_REG_GATE])) begin
            case (reg_req.addr)
                OFF_CONTROL:  d.ctrl     = reg_req.wdata[3:0];
                OFF_STC:      d.stc      = reg_req.wdata;
                OFF_OWN_ADDR: d.own_addr = reg_req.wdata;
                OFF_DATA:     d.data     = reg_req.wdata;
                OFF_BUS_MODE: d.clk_sel  = reg_req.wdata[2:0];
                OFF_IRQ_MASK: d.irq_mask = reg_req.wdata[2:0];
                default:      d.ctrl     = q.ctrl;
            endcase
        end

        // Acknowledge write touches only the value to send
        if (status_wr) begin
            d.ack_tx = reg_req.wdata[BIT_ACK];
        end

        // Reading a flag as 1 arms its clear-by-writing-0
        if (reg_req.rd && q.stc[BIT_REG_GATE] && reg_req.addr == OFF_STATUS) begin
            d.own_armed   = q.own_flag;
            d.bcast_armed = q.bcast_flag;
        end
        if (status_wr && q.own_armed && !reg_req.wdata[BIT_OWN_MATCH]) begin
            d.own_flag  = 1'b0;
            d.own_armed = 1'b0;
        end
        if (status_wr && q.bcast_armed && !reg_req.wdata[BIT_BCAST]) begin
            d.bcast_flag  = 1'b0;
            d.bcast_armed = 1'b0;
        end
        if (data_clr) begin
            d.own_flag   = 1'b0;
            d.bcast_flag = 1'b0;
        end

        // Interrupt status clears on read; events below win over it
        if (reg_req.rd && reg_req.addr == OFF_IRQ_STAT) begin
            d.irq_stat = 3'h0;
        end

        // Link tracking
        case (q.state)
            LINK_IDLE: begin
                d.sda_oe = 1'b0;
            end
            LINK_FRAME: begin
                if (scl_rise) begin
                    d.rx_shift = {q.rx_shift[6:0], sda_s};
                    d.bit_cnt  = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == 4'(FRAME_BITS)) begin
                    d.state  = LINK_ACK;
                    // Receiver drives programmed value only when addressed
                    d.sda_oe = slave_rx && q.addressed && !q.ack_tx;
                end else if (scl_fall && !q.first_frame && tx_mode && q.addressed) begin
                    d.sda_oe   = !q.tx_shift[7];
                    d.tx_shift = {q.tx_shift[6:0], 1'b1};
                end
            end
            LINK_ACK: begin
                if (scl_rise && tx_mode) begin
                    d.ack_rx = sda_s;
                end
                if (scl_fall) begin
                    d.state       = LINK_FRAME;
                    d.bit_cnt     = 4'h0;
                    d.first_frame = 1'b0;
                    d.tx_shift    = {q.data[6:0], 1'b1};
                    d.sda_oe      = tx_mode && q.addressed && !q.data[7];
                end
            end
            default: d.state = LINK_IDLE;
        endcase

        // Byte completion: address compare on first frame, data capture after
        if (addr_done) begin
            d.addressed = !master && (own_hit || gc_hit);
            if (slave_rx && !q.ctrl[BIT_FMT_SEL] && (own_hit || gc_hit)) begin
                d.own_flag             = 1'b1;
                d.irq_stat[IRQ_OWN_MATCH] = 1'b1;
            end
            if (slave_rx && (!q.ctrl[BIT_FMT_SEL] || !q.ctrl[BIT_FMT_SEL2]) && gc_hit) begin
                d.bcast_flag         = 1'b1;
                d.irq_stat[IRQ_BCAST] = 1'b1;
            end
        end else if (byte_end && q.addressed) begin
            if (!tx_mode) begin
                d.data = {q.rx_shift[6:0], sda_s};
            end
            d.irq_stat[IRQ_BYTE_DONE] = 1'b1;
        end

        // Start restarts framing; stop releases the bus
        if (start_det) begin
            d.state       = LINK_FRAME;
            d.bit_cnt     = 4'h0;
            d.first_frame = 1'b1;
            d.addressed   = 1'b0;
            d.sda_oe      = 1'b0;
        end else if (stop_det) begin
            d.state     = LINK_IDLE;
            d.addressed = 1'b0;
            d.sda_oe    = 1'b0;
        end

        // Master mode holds both flags clear
        if (master) begin
            d.own_flag   = 1'b0;
            d.bcast_flag = 1'b0;
        end

        // Hardware standby acts like reset on all control state
        if (hw_standby) begin
            d           = '0;
            d.state     = LINK_IDLE;
            d.stc       = STC_RESET;
            d.own_addr  = OWN_ADDR_RESET;
            d.ack_tx    = ACK_RESET;
            d.scl_prev  = scl_s;
            d.sda_prev  = sda_s;
        end
    end

    // Single register stage for the whole state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q          <= '0;
            q.state    <= LINK_IDLE;
            q.stc      <= STC_RESET;
            q.own_addr <= OWN_ADDR_RESET;
            q.ack_tx   <= ACK_RESET;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs; open-drain data only ever pulls low
    assign rd_data                = q.rd_data;
    assign irq                    = |(q.irq_stat & q.irq_mask);
    assign sda_o                  = 1'b0;
    assign sda_oe                 = q.sda_oe;
    assign async_serial_access_en = !q.stc[BIT_REG_GATE];
    assign pwm_access_en          = q.stc[BIT_REG_GATE];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_addr_frame_own;
        addr_done && slave_rx && !q.ctrl[BIT_FMT_SEL] && (own_hit || gc_hit) && !hw_standby;
    endsequence

    a_own_flag_set: assert property (s_addr_frame_own |=> q.own_flag || master)
        else $error("own address match flag not set");
    a_master_clears_flags: assert property (master && !hw_standby |=> !q.own_flag && !q.bcast_flag)
        else $error("flags not clear in master mode");
    a_bcast_flag_set: assert property (addr_done && slave_rx && gc_hit && !q.ctrl[BIT_FMT_SEL2] && !hw_standby
                                        |=> q.bcast_flag)
        else $error("broadcast flag not set on general call");
    a_data_access_clear: assert property (data_clr && !addr_done && !hw_standby |=> !q.own_flag)
        else $error("own flag survived data access");
    a_ack_capture: assert property ((q.state == LINK_ACK) && scl_rise && tx_mode && !start_det && !hw_standby
                                     |=> q.ack_rx == $past(sda_s))
        else $error("acknowledge from receiver not captured");
    a_ack_write_only: assert property (status_wr && !hw_standby && !((q.state == LINK_ACK) && scl_rise && tx_mode)
                                        |=> q.ack_tx == $past(reg_req.wdata[BIT_ACK]) && $stable(q.ack_rx))
        else $error("acknowledge write disturbed captured value");
    a_ack_drive_low: assert property ((q.state == LINK_FRAME) && scl_fall && q.bit_cnt == 4'(FRAME_BITS)
                                       && slave_rx && q.addressed && !q.ack_tx && !start_det && !stop_det
                                       && !hw_standby |=> sda_oe ##1 1'b1)
        else $error("programmed acknowledge not driven");
    a_standby_clears_stc: assert property (hw_standby |=> q.stc == STC_RESET)
        else $error("control register not cleared by standby");
    a_gate_blocks_read: assert property (reg_req.rd && gated_reg(reg_req.addr) && !q.stc[BIT_REG_GATE]
                                          |=> rd_data == 8'h00)
        else $error("hidden register returned data");

endmodule // i2c_addr_flags_ack_ctrl

// [bench/bus_master_model.sv]
// Purpose: Stand-in for another master on the two-wire bus
// Assumes: Open-drain lines with pull-ups, 48 ns bit period
// Notes:   Clock stands high between frames, as a real master leaves it
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low,
    output logic      ack_seen
);
    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ack_seen = 1'b1;
    end
    // Start, one address frame, ack slot, stop; pull_ack makes this side acknowledge
    task automatic frame(input logic [7:0] b, input logic pull_ack);
        sda_low = 1'b1;
        #24 scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin // Eight bits, MSB first
            #12 sda_low = !b[i];
            #12 scl = 1'b1;
            #24 scl = 1'b0;
        end
        #12 sda_low = pull_ack; // Released unless this side acks
        #12 scl = 1'b1;
        #12 ack_seen = sda_line;
        #12 scl = 1'b0;
        #12 sda_low = 1'b1; // Data falls first so the stop edge is clean
        #12 scl = 1'b1;
        #12 sda_low = 1'b0;
        #24;
    endtask
endmodule // bus_master_model

// [bench/i2c_addr_flags_ack_ctrl_bench.sv]
// Purpose: Self-checking bench for address flags, acknowledge bit and control register
// Assumes: Design assertions live in the design files
// Notes:   Expected read values are queued by the driver and checked one cycle later
`timescale 1ns/1ps
module i2c_addr_flags_ack_ctrl_bench;
    import i2c_flags_pkg::*;
    logic        ref_clk, arst_n, hw_standby, pend;
    reg_req_t    req;
    logic [7:0]  rd_data;
    logic        irq, sda_o, sda_oe, tick, ser_en, pwm_en, scl, sda_low, ack_seen;
    logic [6:0]  own;
    logic [15:0] n;
    logic [31:0] seed;
    int          miscompares, checked, per, want;
    logic [15:0] expq[$];
    wire logic   sda_line = !(sda_low || sda_oe); // Pull-up wins unless someone pulls
    i2c_addr_flags_ack_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n), .hw_standby(hw_standby), .reg_req(req),
        .rd_data(rd_data), .irq(irq), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .master_rate_tick(tick), .async_serial_access_en(ser_en), .pwm_access_en(pwm_en));
    bus_master_model bm (.sda_line(sda_line), .scl(scl), .sda_low(sda_low), .ack_seen(ack_seen));
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    // Expected value and mask are queued; the monitor compares in the answer cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        expq.push_back({m, e & m});
        @(posedge ref_clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
    endtask
    task automatic pin(input logic v, input logic e);
        @(negedge ref_clk);
        check(16'(v), 16'(e));
    endtask
    // Read data stands only in the cycle after the strobe, so sample there
    always @(negedge ref_clk) begin
        if (pend && expq.size() > 0) begin
            n = expq.pop_front();
            check(16'(rd_data & n[15:8]), 16'(n[7:0]));
        end
        pend = req.rd;
    end
    // A hang counts as a failure
    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end
    // Main sequence
    initial begin
        arst_n = 1'b0; hw_standby = 1'b0; req = '0; pend = 1'b0; seed = 32'd80776;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(OFF_STC, 8'hff, STC_RESET);
        pin(ser_en, 1'b1);
        wr(OFF_CONTROL, 8'h0f); // Refused while the gate is shut
        wr(OFF_STC, 8'h70); // Bits 7 and 2 stay clear
        rd(OFF_STC, 8'hff, 8'h70);
        pin(pwm_en, 1'b1);
        rd(OFF_CONTROL, 8'hff, 8'h00);
        rd(8'h0c, 8'hff, 8'h00);
        $display("reset and gate test done");
        seed = lfsr(seed);
        own = seed[6:0] | 7'h01; // Never the general call code
        wr(OFF_OWN_ADDR, {own, 1'b0});
        wr(OFF_IRQ_MASK, 8'h03);
        bm.frame({own, 1'b0}, 1'b0);
        pin(ack_seen, 1'b0);
        pin(sda_o, 1'b0);
        pin(irq, 1'b1);
        rd(OFF_STATUS, 8'h07, 8'h04);
        rd(OFF_IRQ_STAT, 8'h03, 8'h01);
        rd(OFF_IRQ_STAT, 8'h03, 8'h00);
        pin(irq, 1'b0);
        wr(OFF_STATUS, 8'h00);
        rd(OFF_STATUS, 8'h07, 8'h00);
        bm.frame(GEN_CALL_ADDR, 1'b0);
        rd(OFF_STATUS, 8'h07, 8'h06);
        rd(OFF_DATA, 8'hff, 8'h00);
        rd(OFF_STATUS, 8'h07, 8'h00);
        wr(OFF_CONTROL, 8'h04);
        bm.frame(GEN_CALL_ADDR, 1'b0);
        rd(OFF_STATUS, 8'h06, 8'h02);
        wr(OFF_CONTROL, 8'h02);
        rd(OFF_STATUS, 8'h06, 8'h00);
        // Both format selects set: neither flag may rise on a general call
        wr(OFF_CONTROL, 8'h0c);
        bm.frame(GEN_CALL_ADDR, 1'b0);
        rd(OFF_STATUS, 8'h06, 8'h00);
        // Only the second format select set: both flags rise
        wr(OFF_CONTROL, 8'h08);
        bm.frame(GEN_CALL_ADDR, 1'b0);
        rd(OFF_STATUS, 8'h06, 8'h06);
        $display("address flag test done");
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_STATUS, 8'h01);
        rd(OFF_STATUS, 8'h01, 8'h01);
        bm.frame({own, 1'b0}, 1'b0);
        pin(ack_seen, 1'b1);
        wr(OFF_CONTROL, 8'h01);
        bm.frame({own ^ 7'h01, 1'b1}, 1'b1);
        rd(OFF_STATUS, 8'h01, 8'h00);
        wr(OFF_STATUS, 8'h01); // Only the value to send changes
        rd(OFF_STATUS, 8'h01, 8'h00);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_STATUS, 8'h01, 8'h01);
        wr(OFF_CONTROL, 8'h01);
        bm.frame({own ^ 7'h01, 1'b1}, 1'b0);
        rd(OFF_STATUS, 8'h01, 8'h01);
        $display("acknowledge test done");
        // Every extension code with a random clock select; master off between rates
        for (int e = 0; e < 4; e++) begin
            seed = lfsr(seed);
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_STC, {1'b0, 2'(e), 5'h10});
            wr(OFF_BUS_MODE, {5'h00, seed[2:0]});
            wr(OFF_CONTROL, 8'h02);
            want = (int'(RATE_BASE) << seed[2:0]) + (e << RATE_EXT_SH);
            for (int i = 0; i < 6000 && tick !== 1'b1; i++) @(negedge ref_clk);
            @(negedge ref_clk);
            per = 1;
            while (tick !== 1'b1 && per < 6000) begin
                @(negedge ref_clk);
                per++;
            end
            check(16'(per), 16'(want));
        end
        $display("rate test done");
        @(posedge ref_clk);
        hw_standby <= 1'b1;
        @(posedge ref_clk);
        hw_standby <= 1'b0;
        rd(OFF_STC, 8'hff, STC_RESET);
        pin(ser_en, 1'b1);
        $display("standby test done");
        repeat (3) @(posedge ref_clk);
        end_of_test();
    end
endmodule // i2c_addr_flags_ack_ctrl_bench
